// file: src/opc_pkg.sv
// Shared constants and types for the one-time-programmable code memory access link
package opc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RST_WAIT_NS   = 20000;
  localparam int unsigned RST_WAIT_CYC  = (RST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_PULSE_CYC = 16;
  localparam int unsigned PROG_CYC_DEF  = 16;
  localparam int unsigned MEM_BYTES_DEF = 16384;
  localparam int unsigned BLOCK_BYTES   = 256;
  localparam logic [15:0] SEC_ADDR_DEF  = 16'h3FFF;
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;

  // Interface register addresses of the device
  localparam logic [3:0] RA_DEV_CTL = 4'h0;
  localparam logic [3:0] RA_MEM_CTL = 4'h1;
  localparam logic [3:0] RA_ADDR_HI = 4'h2;
  localparam logic [3:0] RA_ADDR_LO = 4'h3;
  localparam logic [3:0] RA_DATA    = 4'h4;
  localparam logic [3:0] RA_STATUS  = 4'h5;
  localparam logic [3:0] RA_CHECKSUM_BYTE_ZERO    = 4'h6;
  localparam logic [3:0] RA_CHECKSUM_BYTE_ONE    = 4'h7;
  localparam logic [3:0] RA_CRC2    = 4'h8;
  localparam logic [3:0] RA_CHECKSUM_BYTE_THREE    = 4'h9;

  localparam logic [7:0] DEV_CORE_HOLD = 8'h04;
  localparam logic [7:0] DEV_RST_ARM   = 8'h02;
  localparam logic [7:0] CTL_ZERO      = 8'h00;
  localparam logic [7:0] MEM_ARM       = 8'h40;
  localparam logic [7:0] MEM_PROG      = 8'h58;

  localparam int unsigned ST_ERR_BIT   = 0;
  localparam int unsigned ST_WLOCK_BIT = 1;
  localparam int unsigned ST_RLOCK_BIT = 2;
  localparam int unsigned ADR_BUSY_BIT = 7;

  localparam logic [31:0] CRC16_POLY = 32'h0000_1021;
  localparam logic [31:0] CRC32_POLY = 32'h04C1_1DB7;
  localparam logic [31:0] CRC_SEED   = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_XOROUT = 32'h0000_0000;

  typedef enum logic [1:0] {
    CMD_NONE = 2'b00,
    CMD_WR   = 2'b01,
    CMD_RD   = 2'b10,
    CMD_ADR  = 2'b11
  } opc_cmd_e;

  // Host command port registers
  localparam logic [3:0] HR_OP      = 4'h0;
  localparam logic [3:0] HR_ADDR_HI = 4'h1;
  localparam logic [3:0] HR_ADDR_LO = 4'h2;
  localparam logic [3:0] HR_DATA    = 4'h3;
  localparam logic [3:0] HR_STATUS  = 4'h4;
  localparam logic [3:0] HR_RES0    = 4'h5;
  localparam logic [3:0] HR_RES3    = 4'h8;

  localparam logic [3:0] OP_PROG_START = 4'h1;
  localparam logic [3:0] OP_ADDR       = 4'h2;
  localparam logic [3:0] OP_PROG_BYTE  = 4'h3;
  localparam logic [3:0] OP_PROG_END   = 4'h4;
  localparam logic [3:0] OP_READ_START = 4'h5;
  localparam logic [3:0] OP_READ_BYTE  = 4'h6;
  localparam logic [3:0] OP_READ_END   = 4'h7;
  localparam logic [3:0] OP_CRC16      = 4'h8;
  localparam logic [3:0] OP_CRC32      = 4'h9;

  localparam logic [1:0] SRC_LIT = 2'h0;
  localparam logic [1:0] SRC_AHI = 2'h1;
  localparam logic [1:0] SRC_ALO = 2'h2;
  localparam logic [1:0] SRC_DAT = 2'h3;
endpackage : opc_pkg

// file: src/opc_link_if.sv
// Link between the programmer and the device: reset and supply pins plus register access
`timescale 1ns/10ps
interface opc_link_if;
  import opc_pkg::*;
  logic       pin_rst_n;
  logic       vpp_on;
  logic       req;
  opc_cmd_e   cmd;
  logic [3:0] reg_addr;
  logic [7:0] wdata;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  modport dev  (input pin_rst_n, vpp_on, req, cmd, reg_addr, wdata,
                output rsp_valid, rsp_data);
  modport host (output pin_rst_n, vpp_on, req, cmd, reg_addr, wdata,
                input rsp_valid, rsp_data);
endinterface : opc_link_if

// file: src/opc_crc.sv
// Byte-serial CRC engine, 16 or 32 bit, MSB first
`timescale 1ns/10ps
module opc_crc import opc_pkg::*; #(
  parameter logic [31:0] SEED   = CRC_SEED,
  parameter logic [31:0] XOROUT = CRC_XOROUT
) (
  input  logic        CLK_SYS,
  input  logic        NRST,
  input  logic        clr,
  input  logic        wide,
  input  logic        en,
  input  logic [7:0]  data,
  output logic [31:0] crc
);
  typedef struct packed {
    logic [31:0] crc;
    logic        wide;
  } opc_crc_s;

  opc_crc_s s_reg;
  opc_crc_s s_next;

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d,
                                           input logic w);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = (w ? r[31] : r[15]) ^ d[i];
      r  = {r[30:0], 1'b0};
      if (fb) begin
        r = r ^ (w ? CRC32_POLY : CRC16_POLY);
      end
    end
    if (!w) begin
      r[31:16] = 16'h0000;
    end
    return r;
  endfunction : crc_step

  always_comb begin
    s_next = s_reg;
    if (clr) begin
      s_next.wide = wide;
      s_next.crc  = wide ? SEED : {16'h0000, SEED[15:0]};
    end else if (en) begin
      s_next.crc = crc_step(s_reg.crc, data, s_reg.wide);
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign crc = s_reg.crc ^ (s_reg.wide ? XOROUT : {16'h0000, XOROUT[15:0]});
endmodule : opc_crc

// file: src/opc_device.sv
// Device end: code memory with program/read sequences, security locks and CRC
// Function
// - Each location programmable once, no erase
// - Programmer waits 20 us after pin reset
// - Device control 0x04 holds core in reset
// - Memory control 0x40 then 0x58 enters program
// - Programmer loads address bytes before data
// - Data write programs byte, address increments
// - Programmer polls busy between data writes
// - Status register shows error flag
// - Leave program: supply off, 0x40, 0x00
// - Device control 0x02 then 0x00 resets device
// - Read: memory control 0x00, then address
// - Data read returns byte, address increments
// - Leave read: 0x40, 0x00, then reset
// - Security bits 7..4 zero block writes
// - Security bits 3..0 zero block reads
// - Status lock flags are global, same at every address
// - No way to remove a lock
// - CRC works even when fully locked
// - Block CRC only on aligned 256 bytes
// - Checksum byte one write starts 32-bit CRC
// - Busy flag set during whole CRC
// - Checksum byte zero write starts block CRC
`timescale 1ns/10ps
module opc_device import opc_pkg::*; #(
  parameter int unsigned MEM_BYTES = MEM_BYTES_DEF,
  parameter int unsigned PROG_CYC  = PROG_CYC_DEF,
  parameter logic [15:0] SEC_ADDR  = SEC_ADDR_DEF
) (
  input  logic    CLK_SYS,
  input  logic    NRST,
  opc_link_if.dev LINK,
  output logic    CORE_HELD,
  output logic    PROG_MODE,
  output logic    BUSY
);
  localparam int unsigned AW = $clog2(MEM_BYTES);

  typedef struct packed {
    logic        rst_s1;
    logic        rst_s2;
    logic        vpp_s1;
    logic        vpp_s2;
    logic        core_held;
    logic        dev_arm;
    logic        prog;
    logic        err;
    logic [7:0]  mem_ctl;
    logic [15:0] addr;
    logic [15:0] prog_cnt;
    logic        crc_run;
    logic [15:0] crc_addr;
    logic [16:0] crc_left;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
    logic        busy_out;
  } opc_dev_s;

  opc_dev_s    s_reg;
  opc_dev_s    s_next;
  // Blank cells read as erased; contents survive every reset
  logic [7:0]  mem [MEM_BYTES] = '{default: ERASED_BYTE};
  logic        written [MEM_BYTES] = '{default: 1'b0};
  logic        mem_we;
  logic [7:0]  cur_byte;
  logic [7:0]  sec_byte;
  logic        wlock;
  logic        rlock;
  logic        busy;
  logic        crc_clr;
  logic        crc_wide;
  logic [31:0] crc_val;

  // Locks are global, so the flags for the addressed cell equal the security byte decode
  assign cur_byte = mem[s_reg.addr[AW-1:0]];
  assign sec_byte = mem[SEC_ADDR[AW-1:0]];
  assign wlock    = ~&sec_byte[7:4];
  assign rlock    = ~&sec_byte[3:0];
  assign busy     = (s_reg.prog_cnt != 16'h0000) || s_reg.crc_run;

  opc_crc u_crc (
    .CLK_SYS (CLK_SYS),
    .NRST    (NRST),
    .clr     (crc_clr),
    .wide    (crc_wide),
    .en      (s_reg.crc_run),
    .data    (mem[s_reg.crc_addr[AW-1:0]]),
    .crc     (crc_val)
  );

  always_comb begin
    s_next           = s_reg;
    s_next.rst_s1    = LINK.pin_rst_n;
    s_next.rst_s2    = s_reg.rst_s1;
    s_next.vpp_s1    = LINK.vpp_on;
    s_next.vpp_s2    = s_reg.vpp_s1;
    s_next.rsp_valid = 1'b0;
    s_next.rsp_data  = 8'h00;
    mem_we           = 1'b0;
    crc_clr          = 1'b0;
    crc_wide         = 1'b0;
    if (s_reg.prog_cnt != 16'h0000) begin
      s_next.prog_cnt = s_reg.prog_cnt - 16'h0001;
    end
    // Lock state is not consulted here: the checksum never exposes raw bytes
    if (s_reg.crc_run) begin
      s_next.crc_addr = s_reg.crc_addr + 16'h0001;
      s_next.crc_left = s_reg.crc_left - 17'h00001;
      if (s_reg.crc_left == 17'h00001) begin
        s_next.crc_run = 1'b0;
      end
    end
    if (!s_reg.rst_s2) begin
      s_next        = '0;
      s_next.rst_s1 = LINK.pin_rst_n;
      s_next.rst_s2 = s_reg.rst_s1;
      s_next.vpp_s1 = LINK.vpp_on;
      s_next.vpp_s2 = s_reg.vpp_s1;
    end else if (LINK.req) begin
      s_next.rsp_valid = 1'b1;
      unique case (LINK.cmd)
        CMD_ADR: begin
          s_next.rsp_data[ADR_BUSY_BIT] = busy;
        end
        CMD_WR: begin
          unique case (LINK.reg_addr)
            RA_DEV_CTL: begin
              s_next.dev_arm = (LINK.wdata == DEV_RST_ARM);
              if (LINK.wdata == DEV_CORE_HOLD) begin
                s_next.core_held = 1'b1;
              end
              if (s_reg.dev_arm && LINK.wdata == CTL_ZERO) begin
                s_next           = '0;
                s_next.rst_s1    = s_reg.rst_s1;
                s_next.rst_s2    = s_reg.rst_s2;
                s_next.vpp_s1    = s_reg.vpp_s1;
                s_next.vpp_s2    = s_reg.vpp_s2;
                s_next.rsp_valid = 1'b1;
              end
            end
            RA_MEM_CTL: begin
              if (s_reg.core_held) begin
                s_next.mem_ctl = LINK.wdata;
                if (s_reg.mem_ctl == MEM_ARM && LINK.wdata == MEM_PROG) begin
                  s_next.prog = 1'b1;
                end else if (LINK.wdata == CTL_ZERO) begin
                  s_next.prog = 1'b0;
                end
              end
            end
            RA_ADDR_HI: begin
              s_next.addr[15:8] = LINK.wdata;
            end
            RA_ADDR_LO: begin
              s_next.addr[7:0] = LINK.wdata;
            end
            RA_DATA: begin
              if (s_reg.core_held && s_reg.prog) begin
                // A written cell is never rewritten and nothing erases it
                if (wlock || busy || !s_reg.vpp_s2 || written[s_reg.addr[AW-1:0]]) begin
                  s_next.err = 1'b1;
                end else begin
                  mem_we          = 1'b1;
                  s_next.prog_cnt = 16'(PROG_CYC);
                end
                s_next.addr = s_reg.addr + 16'h0001;
              end
            end
            RA_CHECKSUM_BYTE_ZERO: begin
              if (!busy) begin
                crc_clr         = 1'b1;
                s_next.crc_run  = 1'b1;
                s_next.crc_addr = {LINK.wdata, 8'h00};
                s_next.crc_left = 17'(BLOCK_BYTES);
              end
            end
            RA_CHECKSUM_BYTE_ONE: begin
              if (!busy) begin
                crc_clr         = 1'b1;
                crc_wide        = 1'b1;
                s_next.crc_run  = 1'b1;
                s_next.crc_addr = 16'h0000;
                s_next.crc_left = 17'(MEM_BYTES);
              end
            end
            default: begin
            end
          endcase
        end
        CMD_RD: begin
          unique case (LINK.reg_addr)
            RA_DEV_CTL: s_next.rsp_data = {5'h00, s_reg.core_held, s_reg.dev_arm, 1'b0};
            RA_MEM_CTL: s_next.rsp_data = s_reg.mem_ctl;
            RA_ADDR_HI: s_next.rsp_data = s_reg.addr[15:8];
            RA_ADDR_LO: s_next.rsp_data = s_reg.addr[7:0];
            RA_DATA: begin
              if (s_reg.core_held && !s_reg.prog) begin
                if (rlock) begin
                  s_next.err = 1'b1;
                end else begin
                  s_next.rsp_data = cur_byte;
                end
                s_next.addr = s_reg.addr + 16'h0001;
              end
            end
            RA_STATUS: begin
              // Reading the status clears the error it reports
              s_next.rsp_data[ST_ERR_BIT]   = s_reg.err;
              s_next.rsp_data[ST_WLOCK_BIT] = wlock;
              s_next.rsp_data[ST_RLOCK_BIT] = rlock;
              s_next.err                    = 1'b0;
            end
            RA_CHECKSUM_BYTE_ZERO: s_next.rsp_data = crc_val[7:0];
            RA_CHECKSUM_BYTE_ONE: s_next.rsp_data = crc_val[15:8];
            RA_CRC2: s_next.rsp_data = crc_val[23:16];
            RA_CHECKSUM_BYTE_THREE: s_next.rsp_data = crc_val[31:24];
            default: s_next.rsp_data = 8'h00;
          endcase
        end
        default: begin
          s_next.rsp_valid = 1'b0;
        end
      endcase
    end
    // Registered copy of the next busy state so the pin comes from a flop
    s_next.busy_out = (s_next.prog_cnt != 16'h0000) || s_next.crc_run;
  end

  always_ff @(posedge CLK_SYS) begin
    if (mem_we) begin
      mem[s_reg.addr[AW-1:0]]     <= LINK.wdata;
      written[s_reg.addr[AW-1:0]] <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign LINK.rsp_valid = s_reg.rsp_valid;
  assign LINK.rsp_data  = s_reg.rsp_data;
  assign CORE_HELD      = s_reg.core_held;
  assign PROG_MODE      = s_reg.prog;
  assign BUSY           = s_reg.busy_out;
endmodule : opc_device

// file: src/opc_host.sv
// Programmer end: runs entry, access and exit sequences on command
`timescale 1ns/10ps
module opc_host import opc_pkg::*; (
  input  logic     CLK_SYS,
  input  logic     NRST,
  opc_link_if.host LINK,
  input  logic [3:0] ADDR,
  input  logic [7:0] WDATA,
  input  logic       WR,
  input  logic       RD,
  output logic [7:0] RDATA
);
  typedef enum logic [2:0] {
    SK_DONE = 3'b000, SK_PIN = 3'b001, SK_WAIT = 3'b010, SK_WR = 3'b011,
    SK_RD = 3'b100, SK_POLL = 3'b101, SK_VPP_ON = 3'b110, SK_VPP_OFF = 3'b111
  } opc_step_e;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00, H_RUN = 2'b01, H_CNT = 2'b10, H_RSP = 2'b11
  } opc_hst_e;
  typedef struct packed {
    opc_step_e  kind;
    logic [3:0] ra;
    logic [1:0] src;
    logic [7:0] lit;
    logic       chk;
  } opc_step_s;
  typedef struct packed {
    opc_hst_e    state;
    logic [3:0]  op;
    logic [2:0]  idx;
    logic [15:0] cnt;
    logic [7:0]  ahi;
    logic [7:0]  alo;
    logic [7:0]  dat;
    logic [31:0] res;
    logic        err;
    logic        pin_rst_n;
    logic        vpp;
    logic        req;
    opc_cmd_e    cmd;
    logic [3:0]  ra;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
  } opc_host_s;

  opc_host_s s_reg;
  opc_host_s s_next;
  opc_step_s st;

  function automatic opc_step_s mk(input opc_step_e k, input logic [3:0] r,
                                   input logic [1:0] sr, input logic [7:0] l, input logic c);
    return '{kind: k, ra: r, src: sr, lit: l, chk: c};
  endfunction : mk

  function automatic opc_step_s step_of(input logic [3:0] op, input logic [2:0] i);
    opc_step_s r;
    r = mk(SK_DONE, 4'h0, SRC_LIT, 8'h00, 1'b0);
    unique case ({op, i})
      {OP_PROG_START, 3'd0}, {OP_READ_START, 3'd0}: r = mk(SK_PIN, 4'h0, SRC_LIT, 8'h00, 1'b0);
      {OP_PROG_START, 3'd1}, {OP_READ_START, 3'd1}: r = mk(SK_WAIT, 4'h0, SRC_LIT, 8'h00, 1'b0);
      {OP_PROG_START, 3'd2}, {OP_READ_START, 3'd2}:
        r = mk(SK_WR, RA_DEV_CTL, SRC_LIT, DEV_CORE_HOLD, 1'b0);
      {OP_PROG_START, 3'd3}: r = mk(SK_WR, RA_MEM_CTL, SRC_LIT, MEM_ARM, 1'b0);
      {OP_PROG_START, 3'd4}: r = mk(SK_WR, RA_MEM_CTL, SRC_LIT, MEM_PROG, 1'b0);
      {OP_PROG_START, 3'd5}: r = mk(SK_VPP_ON, 4'h0, SRC_LIT, 8'h00, 1'b0);
      {OP_READ_START, 3'd3}: r = mk(SK_WR, RA_MEM_CTL, SRC_LIT, CTL_ZERO, 1'b0);
      {OP_ADDR, 3'd0}: r = mk(SK_WR, RA_ADDR_HI, SRC_AHI, 8'h00, 1'b0);
      {OP_ADDR, 3'd1}: r = mk(SK_WR, RA_ADDR_LO, SRC_ALO, 8'h00, 1'b0);
      {OP_PROG_BYTE, 3'd0}: r = mk(SK_WR, RA_DATA, SRC_DAT, 8'h00, 1'b0);
      {OP_PROG_BYTE, 3'd1}, {OP_CRC16, 3'd1}, {OP_CRC32, 3'd1}:
        r = mk(SK_POLL, 4'h0, SRC_LIT, 8'h00, 1'b0);
      {OP_PROG_BYTE, 3'd2}, {OP_READ_BYTE, 3'd1}:
        r = mk(SK_RD, RA_STATUS, SRC_LIT, 8'h00, 1'b1);
      {OP_READ_BYTE, 3'd0}: r = mk(SK_RD, RA_DATA, SRC_LIT, 8'h00, 1'b0);
      {OP_PROG_END, 3'd0}: r = mk(SK_VPP_OFF, 4'h0, SRC_LIT, 8'h00, 1'b0);
      {OP_PROG_END, 3'd1}, {OP_READ_END, 3'd0}:
        r = mk(SK_WR, RA_MEM_CTL, SRC_LIT, MEM_ARM, 1'b0);
      {OP_PROG_END, 3'd2}, {OP_READ_END, 3'd1}:
        r = mk(SK_WR, RA_MEM_CTL, SRC_LIT, CTL_ZERO, 1'b0);
      {OP_PROG_END, 3'd3}, {OP_READ_END, 3'd2}:
        r = mk(SK_WR, RA_DEV_CTL, SRC_LIT, DEV_RST_ARM, 1'b0);
      {OP_PROG_END, 3'd4}, {OP_READ_END, 3'd3}:
        r = mk(SK_WR, RA_DEV_CTL, SRC_LIT, CTL_ZERO, 1'b0);
      {OP_CRC16, 3'd0}: r = mk(SK_WR, RA_CHECKSUM_BYTE_ZERO, SRC_AHI, 8'h00, 1'b0);
      {OP_CRC16, 3'd2}, {OP_CRC32, 3'd4}: r = mk(SK_RD, RA_CHECKSUM_BYTE_ONE, SRC_LIT, 8'h00, 1'b0);
      {OP_CRC16, 3'd3}, {OP_CRC32, 3'd5}: r = mk(SK_RD, RA_CHECKSUM_BYTE_ZERO, SRC_LIT, 8'h00, 1'b0);
      {OP_CRC32, 3'd0}: r = mk(SK_WR, RA_CHECKSUM_BYTE_ONE, SRC_LIT, 8'h00, 1'b0);
      {OP_CRC32, 3'd2}: r = mk(SK_RD, RA_CHECKSUM_BYTE_THREE, SRC_LIT, 8'h00, 1'b0);
      {OP_CRC32, 3'd3}: r = mk(SK_RD, RA_CRC2, SRC_LIT, 8'h00, 1'b0);
      default: r = mk(SK_DONE, 4'h0, SRC_LIT, 8'h00, 1'b0);
    endcase
    return r;
  endfunction : step_of

  assign st = step_of(s_reg.op, s_reg.idx);

  always_comb begin
    s_next       = s_reg;
    s_next.req   = 1'b0;
    s_next.rdata = 8'h00;
    if (RD) begin
      unique case (ADDR)
        HR_OP:      s_next.rdata = {4'h0, s_reg.op};
        HR_ADDR_HI: s_next.rdata = s_reg.ahi;
        HR_ADDR_LO: s_next.rdata = s_reg.alo;
        HR_DATA:    s_next.rdata = s_reg.dat;
        HR_STATUS:  s_next.rdata = {6'h00, s_reg.err, s_reg.state != H_IDLE};
        default: begin
          if (ADDR >= HR_RES0 && ADDR <= HR_RES3) begin
            s_next.rdata = s_reg.res[8*(ADDR - HR_RES0) +: 8];
          end
        end
      endcase
    end
    // Setup registers are frozen while a sequence runs; its steps read them
    if (WR && s_reg.state == H_IDLE) begin
      unique case (ADDR)
        HR_OP: begin
          s_next.op    = WDATA[3:0];
          s_next.idx   = 3'd0;
          s_next.res   = 32'h0000_0000;
          s_next.err   = 1'b0;
          s_next.state = H_RUN;
        end
        HR_ADDR_HI: s_next.ahi = WDATA;
        HR_ADDR_LO: s_next.alo = WDATA;
        HR_DATA:    s_next.dat = WDATA;
        default: begin
        end
      endcase
    end
    unique case (s_reg.state)
      H_IDLE: begin
      end
      H_RUN: begin
        unique case (st.kind)
          SK_DONE: s_next.state = H_IDLE;
          SK_PIN: begin
            s_next.pin_rst_n = 1'b0;
            s_next.cnt       = 16'(RST_PULSE_CYC - 1);
            s_next.state     = H_CNT;
          end
          SK_WAIT: begin
            s_next.cnt   = 16'(RST_WAIT_CYC - 1);
            s_next.state = H_CNT;
          end
          SK_VPP_ON, SK_VPP_OFF: begin
            s_next.vpp = (st.kind == SK_VPP_ON);
            s_next.idx = s_reg.idx + 3'd1;
          end
          default: begin
            s_next.req   = 1'b1;
            s_next.cmd   = (st.kind == SK_WR) ? CMD_WR : (st.kind == SK_RD) ? CMD_RD : CMD_ADR;
            s_next.ra    = st.ra;
            s_next.wdata = (st.src == SRC_AHI) ? s_reg.ahi : (st.src == SRC_ALO) ? s_reg.alo :
                           (st.src == SRC_DAT) ? s_reg.dat : st.lit;
            s_next.state = H_RSP;
          end
        endcase
      end
      H_CNT: begin
        if (s_reg.cnt == 16'h0000) begin
          s_next.pin_rst_n = 1'b1;
          s_next.idx       = s_reg.idx + 3'd1;
          s_next.state     = H_RUN;
        end else begin
          s_next.cnt = s_reg.cnt - 16'h0001;
        end
      end
      H_RSP: begin
        if (LINK.rsp_valid) begin
          s_next.state = H_RUN;
          s_next.idx   = s_reg.idx + 3'd1;
          if (st.kind == SK_POLL && LINK.rsp_data[ADR_BUSY_BIT]) begin
            s_next.idx = s_reg.idx;
          end
          if (st.kind == SK_RD && !st.chk) begin
            s_next.res = {s_reg.res[23:0], LINK.rsp_data};
          end
          if (st.chk && LINK.rsp_data[ST_ERR_BIT]) begin
            s_next.err   = 1'b1;
            s_next.state = H_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      s_reg           <= '0;
      s_reg.pin_rst_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign LINK.pin_rst_n = s_reg.pin_rst_n;
  assign LINK.vpp_on    = s_reg.vpp;
  assign LINK.req       = s_reg.req;
  assign LINK.cmd       = s_reg.cmd;
  assign LINK.reg_addr  = s_reg.ra;
  assign LINK.wdata     = s_reg.wdata;
  assign RDATA          = s_reg.rdata;
endmodule : opc_host

// file: bench/opc_link_properties.sv
// Protocol checker for the programmer/device link
`timescale 1ns/10ps
module opc_link_properties import opc_pkg::*; (
  input logic       CLK_SYS,
  input logic       NRST,
  input logic       pin_rst_n,
  input logic       vpp_on,
  input logic       req,
  input opc_cmd_e   cmd,
  input logic [3:0] reg_addr,
  input logic [7:0] wdata,
  input logic       rsp_valid
);
  logic [7:0]  last_mc;
  logic [7:0]  last_dc;
  logic        poll_due;
  logic        mc_wr;
  logic        dc_wr;
  int unsigned wait_cnt;
  assign mc_wr = req && cmd == CMD_WR && reg_addr == RA_MEM_CTL;
  assign dc_wr = req && cmd == CMD_WR && reg_addr == RA_DEV_CTL;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      last_mc  <= CTL_ZERO;
      last_dc  <= CTL_ZERO;
      poll_due <= 1'b0;
      wait_cnt <= 0;
    end else begin
      if (!pin_rst_n) wait_cnt <= 0;
      else if (wait_cnt < RST_WAIT_CYC) wait_cnt <= wait_cnt + 1;
      if (mc_wr) last_mc <= wdata;
      if (dc_wr) last_dc <= wdata;
      // Any request other than an address read keeps a pending poll pending
      if (req) poll_due <= (cmd == CMD_WR && reg_addr == RA_DATA) || (poll_due && cmd != CMD_ADR);
    end
  end
  property p_answer; req |=> rsp_valid ##1 !rsp_valid; endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered next cycle");
  // Count starts at the edge after the pin rises, hence the one cycle added
  property p_wait; req |-> wait_cnt + 1 >= RST_WAIT_CYC; endproperty
  a_wait: assert property (p_wait)
    else $error("request too soon after pin reset");
  property p_core; mc_wr |-> last_dc == DEV_CORE_HOLD; endproperty
  a_core: assert property (p_core)
    else $error("memory control written without core hold");
  property p_vpp; vpp_on |-> last_mc == MEM_PROG; endproperty
  a_vpp: assert property (p_vpp)
    else $error("supply on outside program mode");
  property p_vpp_off; mc_wr && wdata == MEM_ARM |-> !vpp_on; endproperty
  a_vpp_off: assert property (p_vpp_off)
    else $error("program mode left with supply on");
  property p_poll; req && cmd == CMD_WR && reg_addr == RA_DATA |-> !poll_due; endproperty
  a_poll: assert property (p_poll)
    else $error("data write without busy poll");
  property p_dev_rst; dc_wr && wdata == DEV_RST_ARM |-> ##[2:9] (dc_wr && wdata == CTL_ZERO); endproperty
  a_dev_rst: assert property (p_dev_rst)
    else $error("device reset not completed");
  property p_leave; dc_wr && wdata == DEV_RST_ARM |-> last_mc == CTL_ZERO; endproperty
  a_leave: assert property (p_leave)
    else $error("device reset before mode exit");
endmodule : opc_link_properties

// file: bench/tb.sv
// Self-checking bench: host command port driven, link watched
`timescale 1ns/10ps
module tb import opc_pkg::*;;
  logic       CLK_SYS = 1'b0;
  logic       NRST    = 1'b0;
  logic       WR      = 1'b0;
  logic       RD      = 1'b0;
  logic [3:0] ADDR    = 4'h0;
  logic [7:0] WDATA   = 8'h00;
  logic [7:0] RDATA;
  logic [7:0] st;
  logic       core_held;
  logic       prog_mode;
  logic       busy;
  logic [7:0] mem [512];
  int         mismatches = 0;
  int         tests_run  = 0;
  opc_link_if link ();
  opc_host opc_host_i (.CLK_SYS, .NRST, .LINK(link), .ADDR, .WDATA, .WR, .RD, .RDATA);
  opc_device #(.MEM_BYTES(512), .SEC_ADDR(16'h01FF)) opc_device_i (.CLK_SYS, .NRST,
    .LINK(link), .CORE_HELD(core_held), .PROG_MODE(prog_mode), .BUSY(busy));
  opc_link_properties opc_link_properties_i (.CLK_SYS, .NRST, .pin_rst_n(link.pin_rst_n),
    .vpp_on(link.vpp_on), .req(link.req), .cmd(link.cmd), .reg_addr(link.reg_addr),
    .wdata(link.wdata), .rsp_valid(link.rsp_valid));
  initial forever #5 CLK_SYS = ~CLK_SYS;
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK_SYS);
    WR    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK_SYS);
    RD   <= 1'b0;
    #1 d = RDATA;
  endtask : rd
  task automatic op(input logic [3:0] code);
    int n;
    wr(HR_OP, {4'h0, code});
    for (n = 0; n < 9000; n++) begin
      rd(HR_STATUS, st);
      if (st[0] === 1'b0) break;
    end
    if (n == 9000) begin
      mismatches++;
      final_report();
    end
  endtask : op
  task automatic go_to(input logic [15:0] a);
    wr(HR_ADDR_HI, a[15:8]);
    wr(HR_ADDR_LO, a[7:0]);
    op(OP_ADDR);
  endtask : go_to
  // Programs n bytes from a; e is the error flag expected after each byte
  task automatic prog(input logic [15:0] a, input int n, input logic [7:0] d, input logic e);
    op(OP_PROG_START);
    chk({6'h00, core_held, prog_mode}, 8'h03);
    go_to(a);
    for (int i = 0; i < n; i++) begin
      wr(HR_DATA, d + 8'(i));
      op(OP_PROG_BYTE);
      chk({7'h0, st[1]}, {7'h0, e});
      if (!e) mem[a[8:0] + 9'(i)] = d + 8'(i);
    end
    op(OP_PROG_END);
    chk({6'h00, core_held, prog_mode}, 8'h00);
  endtask : prog
  task automatic rdback(input logic [15:0] a, input int n, input logic e);
    logic [7:0] d;
    op(OP_READ_START);
    go_to(a);
    for (int i = 0; i < n; i++) begin
      op(OP_READ_BYTE);
      chk({7'h0, st[1]}, {7'h0, e});
      rd(HR_RES0, d);
      chk(d, e ? 8'h00 : mem[a[8:0] + 9'(i)]);
    end
    op(OP_READ_END);
  endtask : rdback
  task automatic crc(input logic [3:0] code, input int base, input int w, input logic [31:0] p);
    logic [31:0] c;
    logic [7:0]  d;
    c = CRC_SEED;
    for (int a = base; a < base + (w == 16 ? 256 : 512); a++)
      for (int b = 7; b >= 0; b--)
        c = (c << 1) ^ ((c[w-1] ^ mem[a][b]) ? p : 32'h0);
    wr(HR_ADDR_HI, 8'(base >> 8));
    op(code);
    chk({7'h00, busy}, 8'h00);
    for (int k = 0; k < w / 8; k++) begin
      rd(HR_RES0 + 4'(k), d);
      chk(d, c[8*k +: 8]);
    end
  endtask : crc
  task automatic s_program();
    prog(16'h0100, 3, 8'hA0, 1'b0);
    rdback(16'h0100, 4, 1'b0);
  endtask : s_program
  task automatic s_once();
    prog(16'h0101, 1, 8'h00, 1'b1);
    rdback(16'h0101, 1, 1'b0);
  endtask : s_once
  task automatic s_crc();
    crc(OP_CRC16, 256, 16, CRC16_POLY);
    crc(OP_CRC32, 0, 32, CRC32_POLY);
  endtask : s_crc
  task automatic s_lock();
    prog(16'h01FF, 1, 8'h00, 1'b0);
    rdback(16'h0100, 1, 1'b1);
    prog(16'h0110, 1, 8'h55, 1'b1);
    crc(OP_CRC16, 256, 16, CRC16_POLY);
  endtask : s_lock
  initial begin
    foreach (mem[i]) mem[i] = ERASED_BYTE;
    repeat (12) @(posedge CLK_SYS);
    NRST <= 1'b1;
    s_program();
    s_once();
    s_crc();
    s_lock();
    final_report();
  end
endmodule : tb
